//--- rtl/sst_synth.sv
// Multichannel sinusoid synthesizer with output buffer
// Summary of operation
// - Taylor correction only in standard mode
// - Dropped fraction bits form added correction
// - Linear correction, two multipliers, about 118 dB
// - Quadratic term extends reach to 150 dB
// - Quadratic: extra multipliers, scale/square table
// - Dither whitens spurs; preferred over truncation
// - Channels time-multiplexed, each every N slots
// - Channel 0 first, then ascending order
// - Per-channel rate is clock over N
// - Frequency is increment over 2^W times rate
// - One clock, no domain crossings
// - Reset input registered before use
// - Reset empties buffers, drops output valid
// - Payload meaningful only while valid
// - Event outputs registered, set on detection
// - Data moves on valid/ready stream channels
// - Dither near one address LSB before truncation
// - Rasterized mode: no dither, no correction
`timescale 1ns/1ns
`default_nettype none
`include "sst_cfg.svh"

// Pipeline: take, stage register, buffer, head register
// Output valid three edges after a take into an empty path
// Ready reserves a slot for the word held in the stage
// Reset acts one edge late; hold it at least two edges
// Phase out is taken before dither, matching the accumulator plus offset

// Buffer with a registered head word
// Only the head register drives the draining side
// Ready is registered, so it looks one word ahead
// No reset on storage; pointers alone define content
module sst_fifo #(
   parameter int WIDTH = `SST_FIFO_W,
   parameter int DEPTH = `SST_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Filling side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Draining side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);

   // Storage, pointers and fill level
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic [AW:0] next_count;

   // Handshake qualifiers
   logic full;
   logic empty;
   logic push;
   logic pop;

   assign full = (count == (AW+1)'(DEPTH));
   assign empty = (count == '0);
   assign push = in_valid_in && !full;
   // Head moves to the output register when it is free or taken
   assign pop = !empty && (!out_valid_out || out_ready_in);
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

   // Storage writes
   always_ff @(posedge clock_in) begin
      if (push)
         mem[wr_ptr] <= in_data_in;
   end

   // Pointers and fill level; reset returns to empty
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push)
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         if (pop)
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         count <= next_count;
      end
   end

   // Ready keeps one slot spare for the word already in flight
   always_ff @(posedge clock_in) begin
      if (rst_in)
         in_ready_out <= 1'b0;
      else
         in_ready_out <= (next_count <= (AW+1)'(DEPTH - 2));
   end

   // Registered head word
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         out_valid_out <= 1'b0;
         out_data_out <= '0;
      end else if (pop) begin
         out_valid_out <= 1'b1;
         out_data_out <= mem[rd_ptr];
      end else if (out_ready_in) begin
         out_valid_out <= 1'b0;
      end
   end
endmodule : sst_fifo

// Synthesizer datapath: slots, accumulators, table, correction
// Everything runs on the one clock; no domain crossings
// Mode and raster are sampled with each taken word
module sst_synth
   import sst_pkg::*;
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Static configuration
   input wire logic [1:0] mode_in,
   input wire logic raster_in,
   // Phase input stream: offset high, increment low
   input wire logic s_axis_phase_tvalid_in,
   output logic s_axis_phase_tready_out,
   input wire logic [31:0] s_axis_phase_tdata_in,
   // Sample output stream: cosine high, sine low
   output logic m_axis_data_tvalid_out,
   input wire logic m_axis_data_tready_in,
   output logic [31:0] m_axis_data_tdata_out,
   output logic [`SST_CHAN_W-1:0] m_axis_data_tuser_out,
   output logic [`SST_PHASE_W-1:0] m_axis_phase_tdata_out,
   // Event indications
   output logic event_mode_conflict_out
);
   localparam sst_rom_t SINE_ROM = sst_make_sine();
   localparam sst_dq_t DQ_ROM = sst_make_dq();
   localparam sst_sq_t SQ_ROM = sst_make_sq();

   // Registered reset, slot counter and accumulators
   logic rst_q;
   logic accept;
   logic [`SST_CHAN_W-1:0] chan;
   logic [`SST_CHAN_W-1:0] next_chan;
   logic [`SST_PHASE_W-1:0] acc [`SST_CHAN_N];

   // Phase path, offset added before dither
   logic [`SST_PHASE_W-1:0] pinc;
   logic [`SST_PHASE_W-1:0] poff;
   logic [`SST_PHASE_W-1:0] phase;
   logic [`SST_PHASE_W-1:0] dithered;
   logic [15:0] lfsr;

   // Mode decode
   sst_corr_e corr;
   logic use_dither;
   logic use_lin;
   logic use_quad;

   // Table lookup and correction terms
   logic [`SST_ADDR_W-1:0] addr;
   logic [`SST_FRAC_W-1:0] frac;
   logic signed [`SST_SAMP_W-1:0] s0;
   logic signed [`SST_SAMP_W-1:0] c0;
   logic signed [11:0] dq;
   logic signed [21:0] sq;
   logic signed [27:0] lin_s;
   logic signed [27:0] lin_c;
   logic signed [37:0] quad_s;
   logic signed [37:0] quad_c;

   // Corrected samples, buffer path and event source
   logic signed [17:0] sum_s;
   logic signed [17:0] sum_c;
   logic st_valid;
   logic [`SST_FIFO_W-1:0] st_data;
   logic fifo_ready;
   logic [`SST_FIFO_W-1:0] fifo_out;
   logic conflict;

   // Saturate the corrected sample back to table width
   function automatic logic [`SST_SAMP_W-1:0] sat(
      input logic signed [17:0] v
   );
      if (v > `SST_SAT_MAX)
         return `SST_SAMP_W'(`SST_SAT_MAX);
      else if (v < `SST_SAT_MIN)
         return `SST_SAMP_W'(`SST_SAT_MIN);
      else
         return v[`SST_SAMP_W-1:0];
   endfunction : sat

   // Reset input passes one register; entry into reset lags by a cycle
   always_ff @(posedge clock_in) begin
      rst_q <= rst_in;
   end

   // Input is taken only while the buffer has guaranteed room
   assign accept = s_axis_phase_tvalid_in && s_axis_phase_tready_out;
   assign pinc = s_axis_phase_tdata_in[`SST_PHASE_W-1:0];
   // Narrow offsets are expected left-aligned by the source
   assign poff = s_axis_phase_tdata_in[31:16];

   // Next slot wraps from the last channel back to channel 0
   always_comb begin
      next_chan = chan + 1'b1;
      if (chan == `SST_CHAN_LAST)
         next_chan = `SST_ZERO_CHAN;
   end

   // Time-division slot counter, channel 0 after reset
   always_ff @(posedge clock_in) begin
      if (rst_q)
         chan <= `SST_ZERO_CHAN;
      else if (accept)
         chan <= next_chan;
   end

   // Per-channel accumulators; one step per own slot, so rate is clk/N
   generate
      for (genvar g = 0; g < `SST_CHAN_N; g++) begin : g_acc
         always_ff @(posedge clock_in) begin
            if (rst_q)
               acc[g] <= `SST_ZERO_PHASE;
            else if (accept && chan == g)
               acc[g] <= acc[g] + pinc;
         end
      end
   endgenerate

   // Modular add wraps, so negative tones use rate minus f
   assign phase = acc[chan] + poff;

   // Dither source; advances every cycle so channels decorrelate
   always_ff @(posedge clock_in) begin
      if (rst_q)
         lfsr <= `SST_LFSR_SEED;
      else if (lfsr[0])
         lfsr <= (lfsr >> 1) ^ `SST_LFSR_TAPS;
      else
         lfsr <= lfsr >> 1;
   end

   // Rasterized phase is exact, so neither technique is used
   assign corr = raster_in ? SST_TRUNC : sst_corr_e'(mode_in);

   // One flag per technique keeps the datapath muxes simple
   assign use_dither = (corr == SST_DITHER);
   assign use_lin = (corr == SST_LINEAR) || (corr == SST_QUAD);
   assign use_quad = (corr == SST_QUAD);

   // Noise spans the dropped bits, about one address step
   assign dithered = use_dither
      ? phase + {{(`SST_PHASE_W-`SST_FRAC_W){1'b0}},
                 lfsr[`SST_FRAC_W-1:0]}
      : phase;

   // Table address from the top bits, fraction from the rest
   assign addr = dithered[`SST_PHASE_W-1:`SST_FRAC_W];
   assign frac = phase[`SST_FRAC_W-1:0];
   assign s0 = SINE_ROM[addr];
   assign c0 = SINE_ROM[addr + `SST_QUARTER];

   // Scaled error and its half square come from small tables
   assign dq = {1'b0, DQ_ROM[frac]};
   assign sq = {1'b0, SQ_ROM[frac]};

   // First-order terms: dq table plus two products
   assign lin_s = c0 * dq;
   assign lin_c = s0 * dq;
   // Second-order terms: one more product per output
   assign quad_s = s0 * sq;
   assign quad_c = c0 * sq;

   // Correction is added to the table sample per mode
   always_comb begin
      sum_s = 18'(s0);
      sum_c = 18'(c0);
      if (use_lin) begin
         sum_s = sum_s + 18'(lin_s >>> `SST_LIN_SH);
         sum_c = sum_c - 18'(lin_c >>> `SST_LIN_SH);
      end
      if (use_quad) begin
         sum_s = sum_s - 18'(quad_s >>> `SST_QUAD_SH);
         sum_c = sum_c - 18'(quad_c >>> `SST_QUAD_SH);
      end
   end

   // Compute stage; pushes unconditionally since room was reserved
   always_ff @(posedge clock_in) begin
      if (rst_q) begin
         st_valid <= 1'b0;
         st_data <= '0;
      end else begin
         st_valid <= accept;
         if (accept)
            st_data <= {chan, phase, sat(sum_c), sat(sum_s)};
      end
   end

   // Eight-word buffer between the datapath and the consumer
   sst_fifo #(
      .WIDTH(`SST_FIFO_W),
      .DEPTH(`SST_FIFO_DEPTH)
   ) u_fifo (
      .clock_in(clock_in),
      .rst_in(rst_q),
      .in_valid_in(st_valid),
      .in_ready_out(fifo_ready),
      .in_data_in(st_data),
      .out_valid_out(m_axis_data_tvalid_out),
      .out_ready_in(m_axis_data_tready_in),
      .out_data_out(fifo_out)
   );

   // Output fields straight from the buffer head register
   assign m_axis_data_tdata_out = fifo_out[31:0];
   assign m_axis_phase_tdata_out = fifo_out[47:32];
   assign m_axis_data_tuser_out = fifo_out[49:48];
   assign s_axis_phase_tready_out = fifo_ready;

   // Raster allows no technique but plain truncation
   assign conflict = accept && raster_in && (mode_in != 2'(SST_TRUNC));

   // Flags a sample taken with a mode that raster forbids
   always_ff @(posedge clock_in) begin
      if (rst_q)
         event_mode_conflict_out <= 1'b0;
      else
         event_mode_conflict_out <= conflict;
   end
endmodule : sst_synth

`default_nettype wire

//--- pkg/sst_cfg.svh
// Constants of the sinusoid synthesizer datapath
`ifndef SST_CFG_SVH
`define SST_CFG_SVH

// Channel count and index width
`define SST_CHAN_N 4
`define SST_CHAN_W 2
`define SST_CHAN_LAST 2'h3
// Phase, table address and discarded fraction widths
`define SST_PHASE_W 16
`define SST_ADDR_W 8
`define SST_FRAC_W 8
`define SST_TABLE_N 256
`define SST_QUARTER 8'h40
// Sample width and full-scale amplitude
`define SST_SAMP_W 16
`define SST_AMP 32767
`define SST_SAT_MAX 18'sh07fff
`define SST_SAT_MIN 18'sh38000
// Two pi scaled by 2^13, and the matching shift
`define SST_TWO_PI_Q13 51472
`define SST_TWO_PI_SH 13
// Correction term shifts (linear 2^16, quadratic 2^32)
`define SST_LIN_SH 16
`define SST_QUAD_SH 32
// Output buffer depth and payload width
`define SST_FIFO_DEPTH 8
`define SST_FIFO_W 50
// Dither generator seed and feedback taps
`define SST_LFSR_SEED 16'hace1
`define SST_LFSR_TAPS 16'hb400
// Reset values
`define SST_ZERO_PHASE 16'h0000
`define SST_ZERO_CHAN 2'h0

`endif

//--- pkg/sst_pkg.sv
// Types and table builders of the sinusoid synthesizer datapath
`default_nettype none
`include "sst_cfg.svh"

package sst_pkg;

   // Handling of the discarded phase fraction
   typedef enum logic [1:0] {
      SST_TRUNC,
      SST_DITHER,
      SST_LINEAR,
      SST_QUAD
   } sst_corr_e;

   typedef logic signed [`SST_SAMP_W-1:0] sst_rom_t [`SST_TABLE_N];
   typedef logic [10:0] sst_dq_t [`SST_TABLE_N];
   typedef logic [20:0] sst_sq_t [`SST_TABLE_N];

   // Full-cycle sine table, rational approximation per half cycle
   function automatic sst_rom_t sst_make_sine();
      sst_rom_t rom;
      int u;
      int p;
      int v;
      for (int i = 0; i < `SST_TABLE_N; i++) begin
         u = i % (`SST_TABLE_N / 2);
         p = u * (`SST_TABLE_N / 2 - u);
         v = (`SST_AMP * 4 * p) / (20480 - p);
         if (i >= `SST_TABLE_N / 2)
            v = -v;
         rom[i] = v[`SST_SAMP_W-1:0];
      end
      return rom;
   endfunction : sst_make_sine

   // Phase error scaled to radians times 2^16
   function automatic sst_dq_t sst_make_dq();
      sst_dq_t t;
      int d;
      for (int f = 0; f < `SST_TABLE_N; f++) begin
         d = (f * `SST_TWO_PI_Q13) >> `SST_TWO_PI_SH;
         t[f] = d[10:0];
      end
      return t;
   endfunction : sst_make_dq

   // Half the squared phase error, radians squared times 2^32
   function automatic sst_sq_t sst_make_sq();
      sst_sq_t t;
      int d;
      int s;
      for (int f = 0; f < `SST_TABLE_N; f++) begin
         d = (f * `SST_TWO_PI_Q13) >> `SST_TWO_PI_SH;
         s = (d * d) >> 1;
         t[f] = s[20:0];
      end
      return t;
   endfunction : sst_make_sq

endpackage : sst_pkg

`default_nettype wire

//--- dv/sst_synth_assertions.sv
// Port checker for the sinusoid synthesizer
`timescale 1ns/1ns
`default_nettype none
`include "sst_cfg.svh"
module sst_synth_chk (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Watched ports
   input wire logic [1:0] mode_in,
   input wire logic raster_in,
   input wire logic s_axis_phase_tvalid_in,
   input wire logic s_axis_phase_tready_out,
   input wire logic m_axis_data_tvalid_out,
   input wire logic m_axis_data_tready_in,
   input wire logic [31:0] m_axis_data_tdata_out,
   input wire logic [`SST_CHAN_W-1:0] m_axis_data_tuser_out,
   input wire logic [`SST_PHASE_W-1:0] m_axis_phase_tdata_out,
   input wire logic event_mode_conflict_out
);
   logic rst_d;
   logic [4:0] occ;
   logic [`SST_CHAN_W-1:0] chan;
   wire take = s_axis_phase_tvalid_in && s_axis_phase_tready_out;
   wire give = m_axis_data_tvalid_out && m_axis_data_tready_in;
   wire clash = take && raster_in && (mode_in != 2'h0);
   // Words in flight and next channel; reset reaches the design a cycle late
   always_ff @(posedge clock_in) begin
      rst_d <= rst_in;
      occ <= rst_in ? 5'h00 : occ + 5'(take) - 5'(give);
      chan <= rst_in ? `SST_ZERO_CHAN : chan + `SST_CHAN_W'(give);
   end
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in || rst_d);
   AST_RST_QUIET: assert property (disable iff (1'b0)
      rst_in ##1 rst_in |=> !m_axis_data_tvalid_out
      && !s_axis_phase_tready_out && !event_mode_conflict_out)
      else $error("outputs active in reset");
   AST_RST_LAG: assert property (disable iff (1'b0)
      $fell(rst_in) |-> !s_axis_phase_tready_out ##1
      !s_axis_phase_tready_out ##1 s_axis_phase_tready_out)
      else $error("ready after reset off time");
   AST_CHAN_ORDER: assert property (give |->
      m_axis_data_tuser_out == chan) else $error("channel out of turn");
   AST_HOLD: assert property (m_axis_data_tvalid_out
      && !m_axis_data_tready_in |=> m_axis_data_tvalid_out
      && $stable(m_axis_data_tdata_out) && $stable(m_axis_data_tuser_out)
      && $stable(m_axis_phase_tdata_out)) else $error("output not held");
   AST_NO_PHANTOM: assert property (m_axis_data_tvalid_out |->
      occ != 5'h00) else $error("valid without input");
   AST_LATENCY: assert property (take && occ == 5'h00 |->
      ##3 m_axis_data_tvalid_out) else $error("sample late");
   AST_CAPACITY: assert property (take |-> occ < 5'd11)
      else $error("buffer overrun");
   AST_EVENT_SET: assert property (clash |=>
      event_mode_conflict_out) else $error("event missing");
   AST_EVENT_CAUSE: assert property (event_mode_conflict_out |->
      $past(clash)) else $error("event without cause");
   cover property (give && m_axis_data_tuser_out == `SST_CHAN_LAST);
   cover property (event_mode_conflict_out);
   cover property (m_axis_data_tvalid_out && !s_axis_phase_tready_out);
endmodule : sst_synth_chk
bind sst_synth sst_synth_chk sst_synth_chk_inst (.clock_in, .rst_in,
   .mode_in, .raster_in, .s_axis_phase_tvalid_in, .s_axis_phase_tready_out,
   .m_axis_data_tvalid_out, .m_axis_data_tready_in, .m_axis_data_tdata_out,
   .m_axis_data_tuser_out, .m_axis_phase_tdata_out, .event_mode_conflict_out);
`default_nettype wire

//--- dv/sst_stream_partner.sv
// Downstream consumer model with prompt, slow and stalled pacing
`timescale 1ns/1ns
`default_nettype none
module sst_stream_partner (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rst_in,
   // Pacing: 0 prompt, 1 every other cycle, 2 stalled
   input wire logic [1:0] pace_in,
   // Sample stream
   input wire logic tvalid_in,
   output logic tready_out,
   input wire logic [49:0] word_in
);
   logic tog;
   logic [49:0] rx_q [$];
   assign tready_out = (pace_in == 2'h0) || (pace_in == 2'h1 && tog);
   // Payload kept only on a handshake, ignored otherwise
   always @(posedge clock_in) begin
      tog <= rst_in ? 1'b0 : !tog;
      if (!rst_in && tvalid_in && tready_out)
         rx_q.push_back(word_in);
   end
endmodule : sst_stream_partner
`default_nettype wire

//--- dv/sst_synth_tb.sv
// Self-checking bench for the sinusoid synthesizer
`timescale 1ns/1ns
`default_nettype none
`include "sst_cfg.svh"
module sst_synth_tb
   import sst_pkg::*;
;
   logic clock_in, rst_in, raster_in, s_valid, s_ready, m_valid, m_ready;
   logic evt;
   logic [1:0] mode_in, pace, m_user;
   logic [31:0] s_data, m_data;
   logic [15:0] m_phase, acc [4];
   logic [31:0] tx_q [$];
   logic [17:0] exp_q [$];
   int n_fail, cmp_count, n_evt, ch;
   sst_synth sst_synth_inst (.clock_in, .rst_in, .mode_in, .raster_in,
      .s_axis_phase_tvalid_in(s_valid), .s_axis_phase_tready_out(s_ready),
      .s_axis_phase_tdata_in(s_data), .m_axis_data_tvalid_out(m_valid),
      .m_axis_data_tready_in(m_ready), .m_axis_data_tdata_out(m_data),
      .m_axis_data_tuser_out(m_user), .m_axis_phase_tdata_out(m_phase),
      .event_mode_conflict_out(evt));
   sst_stream_partner sink_inst (.clock_in, .rst_in, .pace_in(pace),
      .tvalid_in(m_valid), .tready_out(m_ready),
      .word_in({m_user, m_phase, m_data}));
   initial begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end
   // Event pulses, one per offending word
   always @(posedge clock_in) if (evt === 1'b1) n_evt++;
   // Whole run is a few hundred cycles; this is ample
   initial begin
      #2000000;
      n_fail++;
      test_done();
   end
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : test_done
   task automatic check(input logic [49:0] seen, input logic [49:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_fail++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask : check
   // Ideal samples at the four quarter points, cosine high
   function automatic logic [31:0] quad(input logic [1:0] q);
      case (q)
         2'h0: quad = 32'h7fff0000;
         2'h1: quad = 32'h00007fff;
         2'h2: quad = 32'h80010000;
         default: quad = 32'h00008001;
      endcase
   endfunction : quad
   // Queue one word; predict channel and phase before the increment
   task automatic push(input logic [15:0] off, input logic [15:0] inc);
      exp_q.push_back({ch[1:0], 16'(acc[ch] + off)});
      tx_q.push_back({off, inc});
      acc[ch] = acc[ch] + inc;
      ch = (ch + 1) % `SST_CHAN_N;
   endtask : push
   task automatic send_all();
      int n;
      s_valid = 1'b1;
      while (tx_q.size() > 0) begin
         s_data = tx_q.pop_front();
         n = 0;
         while (s_ready !== 1'b1 && n < 2000) begin
            @(posedge clock_in);
            #2 n++;
         end
         if (n >= 2000)
            n_fail++;
         @(posedge clock_in);
         #2;
      end
      s_valid = 1'b0;
   endtask : send_all
   task automatic drain();
      int n;
      logic [49:0] r;
      n = 0;
      while (sink_inst.rx_q.size() < exp_q.size() && n < 3000) begin
         @(posedge clock_in);
         n++;
      end
      #2 check(50'(sink_inst.rx_q.size()), 50'(exp_q.size()));
      foreach (exp_q[i]) begin
         r = (i < sink_inst.rx_q.size()) ? sink_inst.rx_q[i] : 'x;
         check(50'(r[49:32]), 50'(exp_q[i]));
         if (exp_q[i][13:0] == 14'h0)
            check(50'(r[31:0]), 50'(quad(exp_q[i][15:14])));
      end
   endtask : drain
   task automatic do_reset(input int cyc);
      rst_in = 1'b1;
      repeat (cyc) @(posedge clock_in);
      #2 check(50'({s_ready, m_valid}), 50'(0));
      rst_in = 1'b0;
      acc = '{default: `SST_ZERO_PHASE};
      ch = 0;
      exp_q.delete();
      sink_inst.rx_q.delete();
      @(posedge clock_in);
      #2 check(50'(s_ready), 50'(0));
      @(posedge clock_in);
      #2 check(50'(s_ready), 50'(1));
   endtask : do_reset
   // Three rounds, one channel wrapping its phase
   task automatic t_order();
      logic [15:0] incs [4] = '{16'h0100, 16'h1000, 16'h4000, 16'hc000};
      logic [15:0] offs [4] = '{16'h0000, 16'h4000, 16'h0000, 16'h8000};
      for (int i = 0; i < 12; i++) push(offs[i % 4], incs[i % 4]);
      send_all();
      drain();
   endtask : t_order
   // Consumer stalls until input is refused, then drains slowly
   task automatic t_backpressure();
      int n;
      do_reset(3);
      pace = 2'h2;
      for (int i = 0; i < 14; i++) push(16'(i << 14), 16'hc000);
      fork
         send_all();
         begin
            n = 0;
            while (s_ready !== 1'b0 && n < 100) begin
               @(posedge clock_in);
               #2 n++;
            end
            check(50'(s_ready), 50'(0));
            repeat (20) @(posedge clock_in);
            #2 check(50'(sink_inst.rx_q.size()), 50'(0));
            pace = 2'h1;
         end
      join
      drain();
   endtask : t_backpressure
   // Each handling of a small phase fraction, then rasterized
   task automatic t_modes();
      logic signed [15:0] s, c;
      logic [1:0] ml [6] = '{SST_TRUNC, SST_DITHER, SST_LINEAR, SST_QUAD,
         SST_QUAD, SST_TRUNC};
      do_reset(3);
      pace = 2'h0;
      for (int k = 0; k < 6; k++) begin
         raster_in = (k >= 4);
         mode_in = ml[k];
         exp_q.delete();
         sink_inst.rx_q.delete();
         repeat (4) push(16'h0080, 16'h0000);
         send_all();
         drain();
         foreach (sink_inst.rx_q[i]) begin
            s = sink_inst.rx_q[i][15:0];
            c = sink_inst.rx_q[i][31:16];
            case (k)
               1: check(50'(s == 0 || s == 817), 50'(1));
               2: check(50'(s > 394 && s < 411), 50'(1));
               3: check(50'(s > 394 && c < 32767), 50'(1));
               default: check(50'(s), 50'(0));
            endcase
         end
      end
      check(50'(n_evt), 50'(4));
   endtask : t_modes
   initial begin
      rst_in = 1'b1;
      raster_in = 1'b0;
      mode_in = SST_TRUNC;
      s_valid = 1'b0;
      s_data = 32'h00000000;
      pace = 2'h0;
      #2 do_reset(6);
      t_order();
      t_backpressure();
      t_modes();
      test_done();
   end
endmodule : sst_synth_tb
`default_nettype wire
